// *** pkg/mcs_pkg.sv ***
// Package of constants and types for the motion command sequencer.
package mcs_pkg;

	// ==========================================================
	// Register map (byte addresses)
	// ==========================================================
	localparam logic [7:0] MCS_OFF_CTRL = 8'h00;
	localparam logic [7:0] MCS_OFF_CMD = 8'h04;
	localparam logic [7:0] MCS_OFF_TARGET = 8'h08;
	localparam logic [7:0] MCS_OFF_START_VEL = 8'h0c;
	localparam logic [7:0] MCS_OFF_RUN_VEL = 8'h10;
	localparam logic [7:0] MCS_OFF_ACCEL = 8'h14;
	localparam logic [7:0] MCS_OFF_DECEL = 8'h18;
	localparam logic [7:0] MCS_OFF_STATUS = 8'h1c;
	localparam logic [7:0] MCS_OFF_POSITION = 8'h20;
	localparam logic [7:0] MCS_OFF_VELOCITY = 8'h24;

	// ==========================================================
	// Control register layout and reset values
	// ==========================================================
	typedef struct packed {
		logic current_enable;
		logic overtravel_stop_select;
		logic alarm_action_select;
		logic hw_limit_enable;
	} mcs_ctrl_t;

	localparam mcs_ctrl_t MCS_CTRL_RESET = 4'h1;
	localparam logic [15:0] MCS_START_VEL_RESET = 16'h0010;
	localparam logic [15:0] MCS_RUN_VEL_RESET = 16'h0100;
	localparam logic [15:0] MCS_ACCEL_RESET = 16'h0064;
	localparam logic [15:0] MCS_DECEL_RESET = 16'h0064;

	// Profile settings carried together.
	typedef struct packed {
		logic [15:0] start_velocity;
		logic [15:0] run_velocity;
		logic [15:0] accel_time;
		logic [15:0] decel_time;
	} mcs_cfg_t;

	// ==========================================================
	// Command field layout and opcodes
	// ==========================================================
	localparam int unsigned MCS_CMD_SEQ_BIT = 8;
	localparam int unsigned MCS_CMD_CV_LSB = 16;
	localparam logic [3:0] MCS_OP_MOVE_ABSOLUTE = 4'h1;
	localparam logic [3:0] MCS_OP_MOVE_CONT_NEG = 4'h2;
	localparam logic [3:0] MCS_OP_MOVE_CONT_POS = 4'h3;
	localparam logic [3:0] MCS_OP_CHANGE_VELOCITY = 4'h4;
	localparam logic [3:0] MCS_OP_SOFT_STOP = 4'h5;
	localparam logic [3:0] MCS_OP_HARD_STOP = 4'h6;
	localparam logic [3:0] MCS_OP_ALARM_CLEAR = 4'h7;

	// ==========================================================
	// Alarm codes and position range
	// ==========================================================
	localparam logic [7:0] MCS_ALARM_OVERTRAVEL = 8'h67;
	localparam logic [7:0] MCS_ALARM_REJECT = 8'ha0;
	localparam logic [23:0] MCS_POS_ILLEGAL = 24'h800000;

	// ==========================================================
	// Timing
	// ==========================================================
	localparam int unsigned MCS_CLK_PERIOD_PS = 4000;
	localparam int unsigned MCS_RAMP_TICK_NS = 1000;
	localparam int unsigned MCS_RAMP_TICK_CYC = MCS_RAMP_TICK_NS * 1000 / MCS_CLK_PERIOD_PS;

	// Motion modes.
	typedef enum logic [1:0] {
		MCS_IDLE,
		MCS_ABS,
		MCS_CNEG,
		MCS_CPOS
	} mcs_mode_t;

endpackage

// *** src/mcs_top.sv ***
// Motion command sequencer: command acceptance, profile, over-travel and APB registers.
// Notes on behaviour
// [R01] Limit enable bit, resets to enabled.
// [R02] Over-travel stops, may alarm 67h, cut current.
// [R03] Over-travel stop soft or hard by select.
// [R04] Continuous moves check limits only while moving.
// [R05] Absolute target range is plus/minus 8388607.
// [R06] Profile: start velocity, ramp, run, ramp down.
// [R07] Change velocity accepted during absolute move.
// [R08] Finished absolute move leaves position at target.
// [R09] Short moves decelerate early, keep exact distance.
// [R10] Absolute move refused when busy, unpowered, alarmed.
// [R11] Refusal: error immediate, alarm A0h in sequence.
// [R12] Commands return at once; further motion refused.
// [R13] Continuous moves negative or positive, no target.
// [R14] Continuous move runs until stop or alarm; alarm A0h leaves it running.
// [R15] Same-direction reissue changes speed on fly.
// [R16] Opposite-direction continuous command is refused.
// [R17] Continuous refused if other motion, unpowered, alarmed.
// [R18] Wait-for-end stalls sequence while moving flag set.
// [R19] Completion means profile done, not shaft position.
// [R20] Host keeps limit detection enabled outside testing.
// [R21] Moving flag follows profile start and end.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/100ps

module mcs_top #(
	parameter int unsigned PHASE_W = 24
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Limit switches
	input wire logic pos_limit_input_in,
	input wire logic neg_limit_input_in,
	// Motor driver
	output logic step_out,
	output logic dir_out,
	output logic current_on_out,
	// Status and sequencer handshake
	input wire logic wait_motion_end_in,
	output logic seq_continue_out,
	output logic moving_flag_out,
	output logic ready_flag_out,
	output logic error_out,
	output logic seq_abort_out
);

	// ==========================================================
	// Registers
	// ==========================================================
	mcs_pkg::mcs_ctrl_t ctrl_r;
	mcs_pkg::mcs_cfg_t cfg_r;
	mcs_pkg::mcs_mode_t mode_r;
	logic [23:0] target_r;
	logic [23:0] pos_r;
	logic [15:0] vel_r;
	logic [15:0] goal_r;
	logic [23:0] ramp_err_r;
	logic [39:0] acc_sum_r;
	logic [PHASE_W-1:0] phase_r;
	logic [7:0] tick_cnt_r;
	logic stopping_r;
	logic dir_r;
	logic alarm_r;
	logic [7:0] alarm_code_r;

	// ==========================================================
	// Bus decode
	// ==========================================================
	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic cmd_wr;
	logic [3:0] op;
	logic from_seq;

	assign pready_out = 1'b1;
	assign wr_en = psel_in & penable_in & pwrite_in;
	assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
	assign addr_ok = (paddr_in[1:0] == 2'h0) && (paddr_in <= mcs_pkg::MCS_OFF_VELOCITY);
	assign pslverr_out = psel_in & penable_in & ~addr_ok;
	assign cmd_wr = wr_en && (paddr_in == mcs_pkg::MCS_OFF_CMD);
	assign op = pwdata_in[3:0];
	assign from_seq = pwdata_in[mcs_pkg::MCS_CMD_SEQ_BIT];

	// ==========================================================
	// Command acceptance
	// ==========================================================
	logic busy;
	logic is_ma;
	logic is_mc;
	logic is_cv;
	logic cont_same;
	logic ma_ok;
	logic mc_ok;
	logic cv_ok;
	logic reject;
	logic start;
	logic respeed;
	logic ot_evt;
	logic hard_stop;
	logic soft_stop;

	assign busy = mode_r != mcs_pkg::MCS_IDLE;
	assign is_ma = cmd_wr && op == mcs_pkg::MCS_OP_MOVE_ABSOLUTE;
	assign is_mc = cmd_wr && (op == mcs_pkg::MCS_OP_MOVE_CONT_NEG ||
		op == mcs_pkg::MCS_OP_MOVE_CONT_POS); // [R13]
	assign is_cv = cmd_wr && op == mcs_pkg::MCS_OP_CHANGE_VELOCITY;
	assign cont_same = (op == mcs_pkg::MCS_OP_MOVE_CONT_NEG && mode_r == mcs_pkg::MCS_CNEG) ||
		(op == mcs_pkg::MCS_OP_MOVE_CONT_POS && mode_r == mcs_pkg::MCS_CPOS);
	assign ma_ok = !busy && ctrl_r.current_enable && !alarm_r &&
		target_r != mcs_pkg::MCS_POS_ILLEGAL; // [R05] [R10] [R12]
	assign mc_ok = ctrl_r.current_enable && !alarm_r &&
		(!busy || (cont_same && !stopping_r)); // [R16] [R17]
	assign cv_ok = mode_r == mcs_pkg::MCS_ABS && !stopping_r; // [R07]
	assign reject = (is_ma && !ma_ok) || (is_mc && !mc_ok) || (is_cv && !cv_ok);
	assign start = (is_ma && ma_ok) || (is_mc && mc_ok && !busy);
	assign respeed = is_mc && mc_ok && busy; // [R15]

	// Limits are only looked at in the direction of travel, once moving.
	assign ot_evt = ctrl_r.hw_limit_enable && busy &&
		((dir_r && pos_limit_input_in) || (!dir_r && neg_limit_input_in)); // [R01] [R04]
	assign hard_stop = (cmd_wr && op == mcs_pkg::MCS_OP_HARD_STOP) ||
		(ot_evt && ctrl_r.overtravel_stop_select); // [R03]
	assign soft_stop = (cmd_wr && op == mcs_pkg::MCS_OP_SOFT_STOP) ||
		(ot_evt && !ctrl_r.overtravel_stop_select); // [R03] [R14]

	// ==========================================================
	// Profile arithmetic
	// ==========================================================
	logic [15:0] span;
	logic [15:0] ta_eff;
	logic [15:0] td_eff;
	logic [23:0] remaining;
	logic near_end;
	logic [15:0] goal_eff;
	logic rising;
	logic [15:0] t_sel;
	logic ramp_tick;
	logic [PHASE_W:0] phase_sum;
	logic step;
	logic [23:0] pos_step;
	logic end_move;

	assign span = (cfg_r.run_velocity > cfg_r.start_velocity) ?
		cfg_r.run_velocity - cfg_r.start_velocity : 16'h0001;
	assign ta_eff = (cfg_r.accel_time == 16'h0000) ? 16'h0001 : cfg_r.accel_time;
	assign td_eff = (cfg_r.decel_time == 16'h0000) ? 16'h0001 : cfg_r.decel_time;
	assign remaining = dir_r ? target_r - pos_r : pos_r - target_r;
	// Decelerate once the steps left, weighted by the ramp-up time, no longer exceed
	// the steps spent ramping up weighted by the ramp-down time.
	assign near_end = mode_r == mcs_pkg::MCS_ABS &&
		({16'h0000, remaining} * {24'h000000, ta_eff}) <= acc_sum_r; // [R09]
	assign goal_eff = (stopping_r || near_end) ? cfg_r.start_velocity : goal_r;
	assign rising = vel_r < goal_eff;
	assign t_sel = rising ? ta_eff : td_eff; // [R06] [R15]
	assign ramp_tick = tick_cnt_r == 8'(mcs_pkg::MCS_RAMP_TICK_CYC - 1);
	assign phase_sum = {1'b0, phase_r} + {{(PHASE_W - 15){1'b0}}, vel_r};
	assign step = busy && phase_sum[PHASE_W] &&
		!(mode_r == mcs_pkg::MCS_ABS && pos_r == target_r);
	assign pos_step = dir_r ? pos_r + 24'h000001 : pos_r - 24'h000001;
	assign end_move = hard_stop ||
		(busy && stopping_r && vel_r <= cfg_r.start_velocity) ||
		(mode_r == mcs_pkg::MCS_ABS && pos_r == target_r); // [R08] [R19]

	// ==========================================================
	// Control and settings registers
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ctrl_r <= mcs_pkg::MCS_CTRL_RESET; // [R01]
		end else if (ot_evt && ctrl_r.alarm_action_select) begin
			ctrl_r.current_enable <= 1'b0; // [R02]
		end else if (wr_en && paddr_in == mcs_pkg::MCS_OFF_CTRL) begin
			ctrl_r <= pwdata_in[3:0];
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cfg_r <= {mcs_pkg::MCS_START_VEL_RESET, mcs_pkg::MCS_RUN_VEL_RESET,
				mcs_pkg::MCS_ACCEL_RESET, mcs_pkg::MCS_DECEL_RESET};
			target_r <= 24'h000000;
		end else if (wr_en) begin
			unique case (paddr_in)
				mcs_pkg::MCS_OFF_TARGET: target_r <= pwdata_in[23:0];
				mcs_pkg::MCS_OFF_START_VEL: cfg_r.start_velocity <= pwdata_in[15:0];
				mcs_pkg::MCS_OFF_RUN_VEL: cfg_r.run_velocity <= pwdata_in[15:0];
				mcs_pkg::MCS_OFF_ACCEL: cfg_r.accel_time <= pwdata_in[15:0];
				mcs_pkg::MCS_OFF_DECEL: cfg_r.decel_time <= pwdata_in[15:0];
				default: begin
				end
			endcase
		end
	end

	// ==========================================================
	// Motion mode
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			mode_r <= mcs_pkg::MCS_IDLE;
			stopping_r <= 1'b0;
			dir_r <= 1'b0;
		end else if (end_move) begin
			mode_r <= mcs_pkg::MCS_IDLE; // [R21]
			stopping_r <= 1'b0;
		end else if (start) begin
			stopping_r <= 1'b0;
			if (is_ma) begin
				mode_r <= mcs_pkg::MCS_ABS;
				dir_r <= $signed(target_r) > $signed(pos_r);
			end else if (op == mcs_pkg::MCS_OP_MOVE_CONT_POS) begin
				mode_r <= mcs_pkg::MCS_CPOS;
				dir_r <= 1'b1;
			end else begin
				mode_r <= mcs_pkg::MCS_CNEG;
				dir_r <= 1'b0;
			end
		end else if (soft_stop && busy) begin
			stopping_r <= 1'b1;
		end
	end

	// ==========================================================
	// Velocity ramp
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tick_cnt_r <= 8'h00;
		end else if (ramp_tick) begin
			tick_cnt_r <= 8'h00;
		end else begin
			tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			vel_r <= 16'h0000;
			goal_r <= 16'h0000;
			ramp_err_r <= 24'h000000;
		end else if (end_move || !busy) begin
			vel_r <= start ? cfg_r.start_velocity : 16'h0000; // [R06]
			goal_r <= cfg_r.run_velocity;
			ramp_err_r <= 24'h000000;
		end else begin
			if (respeed) begin
				goal_r <= cfg_r.run_velocity; // [R15]
			end else if (is_cv && cv_ok) begin
				goal_r <= pwdata_in[mcs_pkg::MCS_CMD_CV_LSB +: 16]; // [R07]
			end
			if (vel_r == goal_eff) begin
				ramp_err_r <= 24'h000000;
			end else if (ramp_tick) begin
				ramp_err_r <= ramp_err_r + {8'h00, span};
			end else if (ramp_err_r >= {8'h00, t_sel}) begin
				ramp_err_r <= ramp_err_r - {8'h00, t_sel};
				vel_r <= rising ? vel_r + 16'h0001 : vel_r - 16'h0001; // [R06]
			end
		end
	end

	// ==========================================================
	// Step generation and position counter
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			phase_r <= '0;
			acc_sum_r <= 40'h0000000000;
			pos_r <= 24'h000000;
		end else begin
			phase_r <= busy ? phase_sum[PHASE_W-1:0] : '0;
			if (start) begin
				acc_sum_r <= 40'h0000000000;
			end else if (step && rising && !near_end) begin
				acc_sum_r <= acc_sum_r + {24'h000000, td_eff}; // [R09]
			end
			if (step && !hard_stop) begin
				pos_r <= pos_step; // [R08]
			end else if (!busy && wr_en && paddr_in == mcs_pkg::MCS_OFF_POSITION) begin
				pos_r <= pwdata_in[23:0];
			end
		end
	end

	// ==========================================================
	// Alarm and refusal reporting
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			alarm_r <= 1'b0;
			alarm_code_r <= 8'h00;
		end else if (ot_evt && ctrl_r.alarm_action_select) begin
			alarm_r <= 1'b1;
			alarm_code_r <= mcs_pkg::MCS_ALARM_OVERTRAVEL; // [R02]
		end else if (reject && from_seq) begin
			alarm_r <= 1'b1;
			alarm_code_r <= mcs_pkg::MCS_ALARM_REJECT; // [R11] [R16] [R17]
		end else if (cmd_wr && op == mcs_pkg::MCS_OP_ALARM_CLEAR) begin
			alarm_r <= 1'b0;
			alarm_code_r <= 8'h00;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			error_out <= 1'b0;
			seq_abort_out <= 1'b0;
			step_out <= 1'b0;
		end else begin
			error_out <= reject && !from_seq; // [R11]
			seq_abort_out <= reject && from_seq; // [R11]
			step_out <= step && !hard_stop;
		end
	end

	// ==========================================================
	// Read data and status outputs
	// ==========================================================
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			prdata_out <= 32'h00000000;
		end else if (rd_setup) begin
			unique case (paddr_in)
				mcs_pkg::MCS_OFF_CTRL: prdata_out <= {28'h0000000, ctrl_r};
				mcs_pkg::MCS_OFF_TARGET: prdata_out <= {8'h00, target_r};
				mcs_pkg::MCS_OFF_START_VEL: prdata_out <= {16'h0000, cfg_r.start_velocity};
				mcs_pkg::MCS_OFF_RUN_VEL: prdata_out <= {16'h0000, cfg_r.run_velocity};
				mcs_pkg::MCS_OFF_ACCEL: prdata_out <= {16'h0000, cfg_r.accel_time};
				mcs_pkg::MCS_OFF_DECEL: prdata_out <= {16'h0000, cfg_r.decel_time};
				mcs_pkg::MCS_OFF_STATUS: prdata_out <= {16'h0000, alarm_code_r, 3'h0,
					dir_r, ctrl_r.current_enable, alarm_r, ready_flag_out, moving_flag_out};
				mcs_pkg::MCS_OFF_POSITION: prdata_out <= {8'h00, pos_r};
				mcs_pkg::MCS_OFF_VELOCITY: prdata_out <= {16'h0000, vel_r};
				default: prdata_out <= 32'h00000000;
			endcase
		end
	end

	assign moving_flag_out = busy; // [R21]
	assign ready_flag_out = !busy && !alarm_r && ctrl_r.current_enable;
	assign seq_continue_out = !(wait_motion_end_in && busy); // [R18]
	assign current_on_out = ctrl_r.current_enable;
	assign dir_out = dir_r;

	// ==========================================================
	// Checks
	// ==========================================================
	lim_reset_on_a: assert property (@(posedge clk_in) !rst_b_in |=> ctrl_r.hw_limit_enable) // [R01]
		else $error("limit enable not set after reset");
	ot_alarm_code_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R02]
		ot_evt && ctrl_r.alarm_action_select |=> alarm_r &&
		alarm_code_r == mcs_pkg::MCS_ALARM_OVERTRAVEL && !current_on_out)
		else $error("over-travel alarm not raised");
	ot_hard_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R03]
		ot_evt && ctrl_r.overtravel_stop_select |=> !moving_flag_out && !step_out)
		else $error("hard stop did not halt motion");
	ma_refused_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R10]
		is_ma && busy |=> $stable(target_r) && (error_out || seq_abort_out))
		else $error("move refused without report");
	abs_done_pos_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R08]
		mode_r == mcs_pkg::MCS_ABS && !hard_stop && !stopping_r ##1 !moving_flag_out
		|-> pos_r == target_r)
		else $error("absolute move ended off target");
	seq_reject_alarm_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R11]
		reject && from_seq && !ot_evt |=> alarm_r && seq_abort_out &&
		alarm_code_r == mcs_pkg::MCS_ALARM_REJECT)
		else $error("sequence refusal did not raise alarm");
	start_profile_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R06]
		start && !hard_stop |=> moving_flag_out && vel_r == $past(cfg_r.start_velocity))
		else $error("profile did not begin at start velocity");
	opp_dir_kept_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R16]
		is_mc && busy && !cont_same && !end_move |=> $stable(mode_r) && $stable(dir_r))
		else $error("direction changed during continuous move");
	wait_motion_end_stall_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // [R18]
		wait_motion_end_in && moving_flag_out |-> !seq_continue_out)
		else $error("sequence not stalled while moving");

endmodule // mcs_top

// *** test/mcs_motor_model.sv ***
// Behavioural model of the stepping motor driver and its two limit switches.
`timescale 1ns/100ps

module mcs_motor_model #(
	parameter int POS_LIM = 40,
	parameter int NEG_LIM = -40
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Motor driver
	input wire logic step_in,
	input wire logic dir_in,
	// Limit switches
	output logic pos_limit_out,
	output logic neg_limit_out
);
	// ==========================================================
	// Shaft position
	// ==========================================================
	int pos_steps;

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			pos_steps <= 0;
		end else if (step_in) begin
			pos_steps <= dir_in ? pos_steps + 1 : pos_steps - 1;
		end
	end

	// ==========================================================
	// Limit switches
	// ==========================================================
	// A switch stays pressed for as long as the carriage is beyond it.
	assign pos_limit_out = (pos_steps >= POS_LIM);
	assign neg_limit_out = (pos_steps <= NEG_LIM);
endmodule // mcs_motor_model

// *** test/tb.sv ***
// Self-checking testbench for the motion command sequencer.
`timescale 1ns/100ps

module tb;
	logic clk_in, rst_b_in, psel_in, penable_in, pwrite_in, wait_motion_end_in, last_err;
	logic [7:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic pready_out, pslverr_out, pos_lim, neg_lim, step_out, dir_out, current_on_out;
	logic seq_continue_out, moving_flag_out, ready_flag_out, error_out, seq_abort_out;
	int n_mismatch = 0;
	int n_tests = 0;

	mcs_top mcs_top_inst (.clk_in(clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
		.pslverr_out(pslverr_out), .pos_limit_input_in(pos_lim), .neg_limit_input_in(neg_lim),
		.step_out(step_out), .dir_out(dir_out), .current_on_out(current_on_out),
		.wait_motion_end_in(wait_motion_end_in), .seq_continue_out(seq_continue_out),
		.moving_flag_out(moving_flag_out), .ready_flag_out(ready_flag_out),
		.error_out(error_out), .seq_abort_out(seq_abort_out));

	mcs_motor_model mcs_motor_model_inst (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.step_in(step_out), .dir_in(dir_out), .pos_limit_out(pos_lim), .neg_limit_out(neg_lim));

	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// ==========================================================
	// Helpers
	// ==========================================================
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= addr;
		pwdata_in <= data;
		@(posedge clk_in);
		penable_in <= 1'b1;
		// Waits as long as the slave stalls; only the watchdog ends a hung transfer.
		do begin
			@(posedge clk_in);
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		last_err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, e, input string name);
		apb(1'b0, a, 32'h0);
		check(name, rd & m, e);
	endtask

	// Issues a command and looks for the refusal pulses over the next two cycles.
	task automatic cmd(input logic [31:0] c, input logic e_err, e_abt, e_mov);
		logic er, ab;
		apb(1'b1, mcs_pkg::MCS_OFF_CMD, c);
		#1;
		er = error_out;
		ab = seq_abort_out;
		@(posedge clk_in);
		#1;
		check("error pulse", er | error_out, e_err);
		check("abort pulse", ab | seq_abort_out, e_abt);
		check("moving flag", moving_flag_out, e_mov);
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 40000 && moving_flag_out !== 1'b0; i++) begin
			@(posedge clk_in);
		end
		#1;
		check("moving end", moving_flag_out, 1'b0);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	initial begin
		repeat (95000) @(posedge clk_in);
		n_mismatch++;
		wrap_up();
	end

	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		{psel_in, penable_in, pwrite_in, wait_motion_end_in} = 4'h0;
		paddr_in = 8'h00;
		pwdata_in = 32'h0;
		rst_b_in = 1'b0;
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		rd_chk(mcs_pkg::MCS_OFF_CTRL, 32'hf, 32'h1, "ctrl reset");
		rd_chk(mcs_pkg::MCS_OFF_STATUS, 32'h3, 32'h0, "status reset");
		rd_chk(8'h40, 32'hffffffff, 32'h0, "unmapped read");
		check("unmapped error", last_err, 1'b1);
		$display("test done: reset");
		cmd(32'h1, 1'b1, 1'b0, 1'b0);
		cmd(32'h101, 1'b0, 1'b1, 1'b0);
		rd_chk(mcs_pkg::MCS_OFF_STATUS, 32'hff04, 32'ha004, "seq alarm");
		apb(1'b1, mcs_pkg::MCS_OFF_CTRL, 32'h9);
		cmd(32'h1, 1'b1, 1'b0, 1'b0);
		cmd(32'h7, 1'b0, 1'b0, 1'b0);
		check("ready", ready_flag_out, 1'b1);
		$display("test done: refusals");
		apb(1'b1, mcs_pkg::MCS_OFF_START_VEL, 32'h8000);
		apb(1'b1, mcs_pkg::MCS_OFF_RUN_VEL, 32'hffff);
		// A long ramp time holds the velocity still while it is read back.
		apb(1'b1, mcs_pkg::MCS_OFF_ACCEL, 32'hffff);
		apb(1'b1, mcs_pkg::MCS_OFF_DECEL, 32'h2);
		apb(1'b1, mcs_pkg::MCS_OFF_TARGET, 32'h8);
		cmd(32'h1, 1'b0, 1'b0, 1'b1);
		rd_chk(mcs_pkg::MCS_OFF_VELOCITY, 32'hffff, 32'h8000, "start velocity");
		apb(1'b1, mcs_pkg::MCS_OFF_ACCEL, 32'h2);
		cmd(32'h1, 1'b1, 1'b0, 1'b1);
		cmd(32'hffff0004, 1'b0, 1'b0, 1'b1);
		@(posedge clk_in);
		wait_motion_end_in <= 1'b1;
		@(posedge clk_in);
		#1;
		check("stall", seq_continue_out, 1'b0);
		wait_idle();
		check("resume", seq_continue_out, 1'b1);
		@(posedge clk_in);
		wait_motion_end_in <= 1'b0;
		rd_chk(mcs_pkg::MCS_OFF_POSITION, 32'hffffff, 32'h8, "position");
		check("steps", mcs_motor_model_inst.pos_steps, 32'h8);
		apb(1'b1, mcs_pkg::MCS_OFF_TARGET, 32'h800000);
		cmd(32'h1, 1'b1, 1'b0, 1'b0);
		apb(1'b1, mcs_pkg::MCS_OFF_TARGET, 32'hfffff8);
		cmd(32'h1, 1'b0, 1'b0, 1'b1);
		check("direction", dir_out, 1'b0);
		cmd(32'h3, 1'b1, 1'b0, 1'b1);
		wait_idle();
		rd_chk(mcs_pkg::MCS_OFF_POSITION, 32'hffffff, 32'hfffff8, "position");
		check("steps", mcs_motor_model_inst.pos_steps, 32'hfffffff8);
		$display("test done: absolute moves");
		cmd(32'h3, 1'b0, 1'b0, 1'b1);
		check("direction", dir_out, 1'b1);
		cmd(32'h2, 1'b1, 1'b0, 1'b1);
		cmd(32'h1, 1'b1, 1'b0, 1'b1);
		apb(1'b1, mcs_pkg::MCS_OFF_RUN_VEL, 32'h8000);
		cmd(32'h3, 1'b0, 1'b0, 1'b1);
		repeat (2000) @(posedge clk_in);
		#1;
		check("still running", moving_flag_out, 1'b1);
		apb(1'b1, mcs_pkg::MCS_OFF_CMD, 32'h5);
		wait_idle();
		$display("test done: continuous moves");
		apb(1'b1, mcs_pkg::MCS_OFF_CTRL, 32'hf);
		cmd(32'h3, 1'b0, 1'b0, 1'b1);
		wait_idle();
		rd_chk(mcs_pkg::MCS_OFF_STATUS, 32'hff0c, 32'h6704, "overtravel");
		check("current off", current_on_out, 1'b0);
		cmd(32'h2, 1'b1, 1'b0, 1'b0);
		cmd(32'h7, 1'b0, 1'b0, 1'b0);
		apb(1'b1, mcs_pkg::MCS_OFF_CTRL, 32'h9);
		cmd(32'h2, 1'b0, 1'b0, 1'b1);
		repeat (1000) @(posedge clk_in);
		#1;
		check("away from limit", moving_flag_out, 1'b1);
		apb(1'b1, mcs_pkg::MCS_OFF_CMD, 32'h6);
		wait_idle();
		$display("test done: overtravel");
		apb(1'b1, mcs_pkg::MCS_OFF_CTRL, 32'h8);
		cmd(32'h3, 1'b0, 1'b0, 1'b1);
		repeat (8000) @(posedge clk_in);
		#1;
		check("limit ignored", moving_flag_out & pos_lim, 1'b1);
		apb(1'b1, mcs_pkg::MCS_OFF_CMD, 32'h6);
		wait_idle();
		$display("test done: limit disable");
		wrap_up();
	end
endmodule // tb
